// ---- shared/ret_pkg.sv ----
// Package for the reloadable 8-bit event timer: register map, reset values, prescale codes.
// Assumes a 4-bit system register bus with one-cycle strobes and read data one cycle later.
`default_nettype none
package ret_pkg;
   // ---------------------------------------------------------------
   // Register offsets (5-bit system register address)
   // ---------------------------------------------------------------
   localparam logic [4:0] ADDR_IRQ_ENABLE   = 5'h00;
   localparam logic [4:0] ADDR_IRQ_REQUEST  = 5'h01;
   localparam logic [4:0] ADDR_PRESCALE     = 5'h02;
   localparam logic [4:0] ADDR_LOW_HALF     = 5'h04;
   localparam logic [4:0] ADDR_HIGH_HALF    = 5'h05;
   localparam logic [4:0] ADDR_SOURCE_EDGE  = 5'h1C;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_TIMER_IRQ   = 2;
   localparam int BIT_EDGE_SELECT = 0;
   localparam int BIT_SRC_SELECT  = 1;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [2:0] PRESCALE_RESET = 3'h0;
   localparam logic [7:0] COUNT_RESET    = 8'h00;
   localparam logic [7:0] COUNT_MAX      = 8'hFF;
   localparam logic [3:0] NIBBLE_ZERO    = 4'h0;
   // Internal source is oscillator / 4
   localparam int         OSC_DIV        = 4;
   // Prescaler width: ratio 2048 needs 11 bits
   localparam int         PRESCALE_BITS  = 11;
   // ---------------------------------------------------------------
   // Prescale codes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      RET_DIV_2048 = 3'h0,
      RET_DIV_512  = 3'h1,
      RET_DIV_128  = 3'h2,
      RET_DIV_32   = 3'h3,
      RET_DIV_8    = 3'h4,
      RET_DIV_4    = 3'h5,
      RET_DIV_2    = 3'h6,
      RET_DIV_1    = 3'h7
   } ret_div_t;
endpackage : ret_pkg
`default_nettype wire

// ---- core/ret_event_sync.sv ----
// Edge detector for the external event pin: two-flop synchroniser, then edge select.
// Assumes the pin is asynchronous to i_sys_clk.
`default_nettype none
module ret_event_sync (
   input  wire logic i_sys_clk,
   input  wire logic i_srst,
   input  wire logic i_pin,
   input  wire logic i_falling,
   output logic      o_edge
);
   logic meta_q, sync_q, last_q;
   logic meta_d, sync_d, last_d;

   always_comb begin
      meta_d = i_pin;
      sync_d = meta_q;
      last_d = sync_q;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         last_q <= last_d;
      end
   end

   // The second and third stages are compared
   assign o_edge = i_falling ? (last_q & ~sync_q) : (~last_q & sync_q);
endmodule : ret_event_sync
`default_nettype wire

// ---- core/ret_prescaler.sv ----
// Power-of-two prescaler: passes one pulse out per N input ticks.
// Assumes i_tick is a one-cycle pulse on i_sys_clk.
`default_nettype none
module ret_prescaler #(
   parameter int WIDTH = ret_pkg::PRESCALE_BITS
) (
   input  wire logic       i_sys_clk,
   input  wire logic       i_srst,
   input  wire logic       i_tick,
   input  wire logic [2:0] i_sel,
   output logic            o_pulse
);
   logic [WIDTH-1:0] cnt_q, cnt_d;

   // Number of stages for a prescale code
   function automatic int stages(input logic [2:0] sel);
      case (ret_pkg::ret_div_t'(sel))
         ret_pkg::RET_DIV_2048: stages = 11;
         ret_pkg::RET_DIV_512:  stages = 9;
         ret_pkg::RET_DIV_128:  stages = 7;
         ret_pkg::RET_DIV_32:   stages = 5;
         ret_pkg::RET_DIV_8:    stages = 3;
         ret_pkg::RET_DIV_4:    stages = 2;
         ret_pkg::RET_DIV_2:    stages = 1;
         default:               stages = 0;
      endcase
   endfunction : stages

   logic [WIDTH-1:0] mask;
   always_comb begin
      mask  = WIDTH'((1 << stages(i_sel)) - 1);
      cnt_d = i_tick ? cnt_q + 1'b1 : cnt_q;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) cnt_q <= '0;
      else        cnt_q <= cnt_d;
   end

   // Output is the carry out of the selected stage: one tick-wide pulse per N ticks
   assign o_pulse = i_tick && ((cnt_q & mask) == mask);
endmodule : ret_prescaler
`default_nettype wire

// ---- core/ret_timer.sv ----
// Reloadable 8-bit event timer: reload/count halves, prescaler, source and edge select,
// overflow request with enable and HALT wake. Assumes a 4-bit system register port.
//
// The address-and-strobe port is this design's own decision.
`default_nettype none
module ret_timer (
   input  wire logic       i_sys_clk,
   input  wire logic       i_srst,
   input  wire logic [4:0] i_addr,
   input  wire logic [3:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic       i_external_event_pin,
   output logic [3:0]      o_rdata,
   output logic            o_service_req,
   output logic            o_halt_wake,
   output logic [7:0]      o_count
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [3:0] reload_low_half_q,  reload_low_half_d;
   logic [3:0] reload_high_half_q, reload_high_half_d;
   logic [7:0] count_q,            count_d;
   logic [3:0] count_low_latch_q,  count_low_latch_d;
   logic [2:0] prescale_select_q,  prescale_select_d;
   logic       event_edge_select_q, event_edge_select_d;
   logic       count_source_select_q, count_source_select_d;
   logic       timer_irq_enable_q, timer_irq_enable_d;
   logic       timer_irq_request_q, timer_irq_request_d;
   logic [1:0] osc_div_q,          osc_div_d;
   logic [3:0] rdata_q,            rdata_d;

   logic       ext_edge;
   logic       osc_tick;
   logic       tick;
   logic       prescaled_event;
   logic       overflow;

   // ---------------------------------------------------------------
   // Count source
   // ---------------------------------------------------------------
   ret_event_sync u_sync (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .i_pin     (i_external_event_pin),
      .i_falling (event_edge_select_q),
      .o_edge    (ext_edge)
   );

   always_comb begin
      osc_div_d = osc_div_q + 2'h1;
   end
   assign osc_tick = (osc_div_q == 2'(ret_pkg::OSC_DIV - 1));

   // Source multiplexer
   assign tick = count_source_select_q ? ext_edge : osc_tick;

   ret_prescaler #(
      .WIDTH (ret_pkg::PRESCALE_BITS)
   ) u_pre (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .i_tick    (tick),
      .i_sel     (prescale_select_q),
      .o_pulse   (prescaled_event)
   );

   assign overflow = prescaled_event && (count_q == ret_pkg::COUNT_MAX);

   // ---------------------------------------------------------------
   // Register writes and counting
   // ---------------------------------------------------------------
   logic wr_high;
   assign wr_high = i_wr && (i_addr == ret_pkg::ADDR_HIGH_HALF);

   always_comb begin
      reload_low_half_d     = reload_low_half_q;
      reload_high_half_d    = reload_high_half_q;
      prescale_select_d     = prescale_select_q;
      event_edge_select_d   = event_edge_select_q;
      count_source_select_d = count_source_select_q;
      timer_irq_enable_d    = timer_irq_enable_q;
      timer_irq_request_d   = timer_irq_request_q;
      count_d               = count_q;
      if (i_wr) begin
         case (i_addr)
            ret_pkg::ADDR_LOW_HALF:  reload_low_half_d  = i_wdata;
            ret_pkg::ADDR_HIGH_HALF: reload_high_half_d = i_wdata;
            ret_pkg::ADDR_PRESCALE:  prescale_select_d  = i_wdata[2:0];
            ret_pkg::ADDR_IRQ_ENABLE: timer_irq_enable_d = i_wdata[ret_pkg::BIT_TIMER_IRQ];
            ret_pkg::ADDR_IRQ_REQUEST: begin
               if (!i_wdata[ret_pkg::BIT_TIMER_IRQ]) timer_irq_request_d = 1'b0;
            end
            ret_pkg::ADDR_SOURCE_EDGE: begin
               event_edge_select_d   = i_wdata[ret_pkg::BIT_EDGE_SELECT];
               count_source_select_d = i_wdata[ret_pkg::BIT_SRC_SELECT];
            end
            default: ;
         endcase
      end
      if (wr_high) begin
         count_d = {i_wdata, reload_low_half_q};
      end else if (overflow) begin
         count_d = {reload_high_half_q, reload_low_half_q};
      end else if (prescaled_event) begin
         count_d = count_q + 8'h01;
      end
      if (overflow) timer_irq_request_d = 1'b1;
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   always_comb begin
      count_low_latch_d = count_low_latch_q;
      rdata_d           = ret_pkg::NIBBLE_ZERO;
      if (i_rd) begin
         case (i_addr)
            ret_pkg::ADDR_HIGH_HALF: begin
               rdata_d           = count_q[7:4];
               count_low_latch_d = count_q[3:0];
            end
            ret_pkg::ADDR_LOW_HALF: rdata_d = count_low_latch_q;
            ret_pkg::ADDR_PRESCALE: rdata_d = {1'b0, prescale_select_q};
            ret_pkg::ADDR_IRQ_ENABLE: rdata_d[ret_pkg::BIT_TIMER_IRQ] = timer_irq_enable_q;
            ret_pkg::ADDR_IRQ_REQUEST: rdata_d[ret_pkg::BIT_TIMER_IRQ] = timer_irq_request_q;
            default: rdata_d = ret_pkg::NIBBLE_ZERO;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         reload_low_half_q     <= ret_pkg::NIBBLE_ZERO;
         reload_high_half_q    <= ret_pkg::NIBBLE_ZERO;
         count_q               <= ret_pkg::COUNT_RESET;
         count_low_latch_q     <= ret_pkg::NIBBLE_ZERO;
         prescale_select_q     <= ret_pkg::PRESCALE_RESET;
         event_edge_select_q   <= 1'b0;
         count_source_select_q <= 1'b0;
         timer_irq_enable_q    <= 1'b0;
         timer_irq_request_q   <= 1'b0;
         osc_div_q             <= 2'h0;
         rdata_q               <= ret_pkg::NIBBLE_ZERO;
      end else begin
         reload_low_half_q     <= reload_low_half_d;
         reload_high_half_q    <= reload_high_half_d;
         count_q               <= count_d;
         count_low_latch_q     <= count_low_latch_d;
         prescale_select_q     <= prescale_select_d;
         event_edge_select_q   <= event_edge_select_d;
         count_source_select_q <= count_source_select_d;
         timer_irq_enable_q    <= timer_irq_enable_d;
         timer_irq_request_q   <= timer_irq_request_d;
         osc_div_q             <= osc_div_d;
         rdata_q               <= rdata_d;
      end
   end

   assign o_rdata       = rdata_q;
   assign o_count       = count_q;
   assign o_service_req = timer_irq_request_q & timer_irq_enable_q;
   assign o_halt_wake   = timer_irq_request_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_high_write_loads;
      @(posedge i_sys_clk) disable iff (i_srst)
      wr_high |=> (count_q == {$past(i_wdata), $past(reload_low_half_q)});
   endproperty
   a_high_write_loads: assert property (p_high_write_loads) else $error("high write did not load counter");

   property p_reload;
      @(posedge i_sys_clk) disable iff (i_srst)
      (overflow && !wr_high) |=> (count_q == {$past(reload_high_half_q), $past(reload_low_half_q)});
   endproperty
   a_reload: assert property (p_reload) else $error("overflow did not reload");

   property p_overflow_sets;
      @(posedge i_sys_clk) disable iff (i_srst)
      overflow |=> timer_irq_request_q;
   endproperty
   a_overflow_sets: assert property (p_overflow_sets) else $error("overflow did not set request");

   property p_enable_gate;
      @(posedge i_sys_clk) disable iff (i_srst)
      o_service_req |-> (timer_irq_enable_q && timer_irq_request_q);
   endproperty
   a_enable_gate: assert property (p_enable_gate) else $error("service request without enable");

   property p_wake;
      @(posedge i_sys_clk) disable iff (i_srst)
      overflow |=> o_halt_wake;
   endproperty
   a_wake: assert property (p_wake) else $error("overflow did not wake");

   property p_step;
      @(posedge i_sys_clk) disable iff (i_srst)
      (prescaled_event && !overflow && !wr_high) |=> (count_q == $past(count_q) + 8'h01);
   endproperty
   a_step: assert property (p_step) else $error("counter did not step");

   property p_hold;
      @(posedge i_sys_clk) disable iff (i_srst)
      (!prescaled_event && !wr_high) |=> $stable(count_q);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved without a pulse");

   property p_read_pair;
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_rd && i_addr == ret_pkg::ADDR_HIGH_HALF) ##1 (i_rd && i_addr == ret_pkg::ADDR_LOW_HALF)
         |=> (o_rdata == $past(count_q[3:0], 2));
   endproperty
   a_read_pair: assert property (p_read_pair) else $error("low read not consistent");

   property p_sticky;
      @(posedge i_sys_clk) disable iff (i_srst)
      (timer_irq_request_q && !(i_wr && i_addr == ret_pkg::ADDR_IRQ_REQUEST)) |=> timer_irq_request_q;
   endproperty
   a_sticky: assert property (p_sticky) else $error("request lost without clear");

   property p_internal_rate;
      @(posedge i_sys_clk) disable iff (i_srst)
      (!count_source_select_q && tick) |=> !osc_tick [*3];
   endproperty
   a_internal_rate: assert property (p_internal_rate) else $error("internal source not divided by four");

   property p_internal_src;
      @(posedge i_sys_clk) disable iff (i_srst)
      !count_source_select_q |-> (tick == osc_tick);
   endproperty
   a_internal_src: assert property (p_internal_src) else $error("internal source not selected");

   property p_external_src;
      @(posedge i_sys_clk) disable iff (i_srst)
      count_source_select_q |-> (tick == ext_edge);
   endproperty
   a_external_src: assert property (p_external_src) else $error("event pin not selected");

   property p_edge_single;
      @(posedge i_sys_clk) disable iff (i_srst)
      ext_edge ##1 $stable(event_edge_select_q) |-> !ext_edge;
   endproperty
   a_edge_single: assert property (p_edge_single) else $error("event edge longer than one cycle");

   property p_ratio_one;
      @(posedge i_sys_clk) disable iff (i_srst)
      (prescale_select_q == ret_pkg::RET_DIV_1) |-> (prescaled_event == tick);
   endproperty
   a_ratio_one: assert property (p_ratio_one) else $error("ratio one does not pass every tick");

   property p_pulse_needs_tick;
      @(posedge i_sys_clk) disable iff (i_srst)
      prescaled_event |-> tick;
   endproperty
   a_pulse_needs_tick: assert property (p_pulse_needs_tick) else $error("prescaler pulse without tick");

   // ---------------------------------------------------------------
   // Assertions on register writes, reads and reset
   // ---------------------------------------------------------------
   property p_prescale_write;
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_wr && i_addr == ret_pkg::ADDR_PRESCALE) |=> (prescale_select_q == $past(i_wdata[2:0]));
   endproperty
   a_prescale_write: assert property (p_prescale_write) else $error("prescale write lost");

   property p_source_write;
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_wr && i_addr == ret_pkg::ADDR_SOURCE_EDGE)
         |=> ((event_edge_select_q == $past(i_wdata[ret_pkg::BIT_EDGE_SELECT]))
             && (count_source_select_q == $past(i_wdata[ret_pkg::BIT_SRC_SELECT])));
   endproperty
   a_source_write: assert property (p_source_write) else $error("source or edge write lost");

   property p_low_store;
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_wr && i_addr == ret_pkg::ADDR_LOW_HALF) |=> (reload_low_half_q == $past(i_wdata));
   endproperty
   a_low_store: assert property (p_low_store) else $error("low reload write lost");

   property p_high_store;
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_wr && i_addr == ret_pkg::ADDR_HIGH_HALF) |=> (reload_high_half_q == $past(i_wdata));
   endproperty
   a_high_store: assert property (p_high_store) else $error("high reload write lost");

   property p_reload_stable;
      @(posedge i_sys_clk) disable iff (i_srst)
      !(i_wr && (i_addr == ret_pkg::ADDR_LOW_HALF || i_addr == ret_pkg::ADDR_HIGH_HALF))
         |=> $stable({reload_high_half_q, reload_low_half_q});
   endproperty
   a_reload_stable: assert property (p_reload_stable) else $error("reload changed without a write");

   property p_latch_high_read;
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_rd && i_addr == ret_pkg::ADDR_HIGH_HALF)
         |=> ((o_rdata == $past(count_q[7:4])) && (count_low_latch_q == $past(count_q[3:0])));
   endproperty
   a_latch_high_read: assert property (p_latch_high_read) else $error("high read did not latch");

   property p_rdata_idle;
      @(posedge i_sys_clk) disable iff (i_srst)
      !i_rd |=> (o_rdata == ret_pkg::NIBBLE_ZERO);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data stood too long");

   property p_request_clear;
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_wr && i_addr == ret_pkg::ADDR_IRQ_REQUEST && !i_wdata[ret_pkg::BIT_TIMER_IRQ] && !overflow)
         |=> !timer_irq_request_q;
   endproperty
   a_request_clear: assert property (p_request_clear) else $error("request not cleared");

   property p_no_spurious;
      @(posedge i_sys_clk) disable iff (i_srst)
      (!overflow && !timer_irq_request_q) |=> !timer_irq_request_q;
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("request set without overflow");

   property p_enable_write;
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_wr && i_addr == ret_pkg::ADDR_IRQ_ENABLE)
         |=> (timer_irq_enable_q == $past(i_wdata[ret_pkg::BIT_TIMER_IRQ]));
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable write lost");

   property p_reset_clears;
      @(posedge i_sys_clk)
      i_srst |=> ((count_q == ret_pkg::COUNT_RESET) && (reload_low_half_q == ret_pkg::NIBBLE_ZERO)
         && (reload_high_half_q == ret_pkg::NIBBLE_ZERO) && !timer_irq_request_q);
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear state");
endmodule : ret_timer
`default_nettype wire

// ---- verification/ret_event_model.sv ----
// Far-side model of the external event source that drives the timer's event pin.
// Assumes the caller runs on i_sys_clk; the pin idles low between bursts.
`default_nettype none
module ret_event_model (
   input  wire logic i_sys_clk,
   output logic      o_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   initial o_pin = 1'h0;

   // -------------------------------------------------------------
   // Pulse burst
   // -------------------------------------------------------------
   // Each level is held three clocks, above the two-period minimum,
   // so the period also clears the prescaled sampling limit
   task automatic pulses(input int n);
      for (int k = 0; k < n; k++) begin
         repeat (3) @(posedge i_sys_clk);
         o_pin <= 1'h1;
         repeat (3) @(posedge i_sys_clk);
         o_pin <= 1'h0;
      end
      repeat (6) @(posedge i_sys_clk);
   endtask : pulses
endmodule : ret_event_model
`default_nettype wire

// ---- verification/tb_ret_timer.sv ----
// Self-checking testbench for the reloadable event timer.
// Assumes the register port of the package map and the event source model beside it.
`default_nettype none
module tb_ret_timer;
   timeunit 1ns;
   timeprecision 1ps;

   `define CHK(what, exp, got) \
      begin \
         checked++; \
         if ((got) !== (exp)) begin \
            bad_count++; \
            $display("[FAIL] %s expected %h seen %h", what, exp, got); \
         end \
      end

   logic       clk;
   logic       srst;
   logic       wr;
   logic       rd;
   logic       pin;
   logic       svc;
   logic       wake;
   logic [4:0] addr;
   logic [3:0] wdata;
   logic [3:0] rdata;
   logic [7:0] cnt;
   int         bad_count;
   int         checked;
   int         cyc;
   int         n;
   int         ratio [8] = '{2048, 512, 128, 32, 8, 4, 2, 1};

   ret_timer ret_timer_i (
      .i_sys_clk            (clk),
      .i_srst               (srst),
      .i_addr               (addr),
      .i_wdata              (wdata),
      .i_wr                 (wr),
      .i_rd                 (rd),
      .i_external_event_pin (pin),
      .o_rdata              (rdata),
      .o_service_req        (svc),
      .o_halt_wake          (wake),
      .o_count              (cnt)
   );

   ret_event_model ret_event_model_i (
      .i_sys_clk (clk),
      .o_pin     (pin)
   );

   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         print_verdict();
      end
   end

   task automatic wr_reg(input logic [4:0] a, input logic [3:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge clk);
      wr    <= 1'h0;
      #1;
   endtask : wr_reg

   task automatic expect_reg(input string what, input logic [4:0] a, input logic [3:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'h1;
      @(posedge clk);
      rd   <= 1'h0;
      #1;
      `CHK(what, e, rdata)
   endtask : expect_reg

   // Cycles from now until the counter next changes
   task automatic wait_step(output int k);
      logic [7:0] p;
      p = cnt;
      k = 0;
      while (cnt === p && k < 9000) begin
         @(negedge clk);
         k++;
      end
   endtask : wait_step

   // -------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------
   initial begin
      srst  = 1'h1;
      wr    = 1'h0;
      rd    = 1'h0;
      addr  = 5'h00;
      wdata = 4'h0;
      repeat (16) @(posedge clk);
      srst <= 1'h0;
      expect_reg("count high", ret_pkg::ADDR_HIGH_HALF, 4'h0);
      expect_reg("count low", ret_pkg::ADDR_LOW_HALF, 4'h0);
      expect_reg("request", ret_pkg::ADDR_IRQ_REQUEST, 4'h0);
      expect_reg("enable", ret_pkg::ADDR_IRQ_ENABLE, 4'h0);
      expect_reg("prescale", ret_pkg::ADDR_PRESCALE, {1'h0, ret_pkg::PRESCALE_RESET});
      expect_reg("source edge", ret_pkg::ADDR_SOURCE_EDGE, 4'h0);
      wr_reg(5'h03, 4'hF);
      expect_reg("unmapped", 5'h03, 4'h0);
      $display("test reset done");

      // Event pin source, rising then falling edge, ratios one and two: apart from the high-half load, the counter only moves on pulses
      wr_reg(ret_pkg::ADDR_SOURCE_EDGE, 4'h2);
      wr_reg(ret_pkg::ADDR_PRESCALE, 4'h7);
      expect_reg("prescale rb", ret_pkg::ADDR_PRESCALE, 4'h7);
      wr_reg(ret_pkg::ADDR_LOW_HALF, 4'hF);
      `CHK("count before high", 8'h00, cnt)
      wr_reg(ret_pkg::ADDR_HIGH_HALF, 4'h0);
      `CHK("count loaded", 8'h0F, cnt)
      expect_reg("high first", ret_pkg::ADDR_HIGH_HALF, 4'h0);
      ret_event_model_i.pulses(1);
      `CHK("pin step", 8'h10, cnt)
      expect_reg("latched low", ret_pkg::ADDR_LOW_HALF, 4'hF);
      expect_reg("new high", ret_pkg::ADDR_HIGH_HALF, 4'h1);
      expect_reg("new low", ret_pkg::ADDR_LOW_HALF, 4'h0);
      ret_event_model_i.pulses(3);
      `CHK("rising edges", 8'h13, cnt)
      wr_reg(ret_pkg::ADDR_SOURCE_EDGE, 4'h3);
      ret_event_model_i.pulses(2);
      `CHK("falling edges", 8'h15, cnt)
      wr_reg(ret_pkg::ADDR_SOURCE_EDGE, 4'h2);
      wr_reg(ret_pkg::ADDR_PRESCALE, 4'h6);
      ret_event_model_i.pulses(4);
      `CHK("pin divided by 2", 8'h17, cnt)
      $display("test event pin done");

      // Internal source, ratio one, reload FE: overflow every eight clocks
      wr_reg(ret_pkg::ADDR_PRESCALE, 4'h7);
      wr_reg(ret_pkg::ADDR_LOW_HALF, 4'hE);
      wr_reg(ret_pkg::ADDR_HIGH_HALF, 4'hF);
      wr_reg(ret_pkg::ADDR_SOURCE_EDGE, 4'h0);
      n = 0;
      while (wake !== 1'h1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      #1;
      `CHK("halt wake", 1'h1, wake)
      `CHK("reloaded", 8'hFE, cnt)
      `CHK("service masked", 1'h0, svc)
      wr_reg(ret_pkg::ADDR_SOURCE_EDGE, 4'h2);
      expect_reg("request set", ret_pkg::ADDR_IRQ_REQUEST, 4'h4);
      wr_reg(ret_pkg::ADDR_IRQ_REQUEST, 4'hF);
      expect_reg("request held", ret_pkg::ADDR_IRQ_REQUEST, 4'h4);
      wr_reg(ret_pkg::ADDR_IRQ_ENABLE, 4'h4);
      `CHK("service enabled", 1'h1, svc)
      expect_reg("enable rb", ret_pkg::ADDR_IRQ_ENABLE, 4'h4);
      wr_reg(ret_pkg::ADDR_IRQ_REQUEST, 4'h0);
      `CHK("service cleared", 1'h0, svc)
      `CHK("wake cleared", 1'h0, wake)
      expect_reg("request clear", ret_pkg::ADDR_IRQ_REQUEST, 4'h0);
      $display("test overflow done");

      // Mid-run reset: counter, low reload half, prescale and request return to their reset values
      @(posedge clk);
      srst <= 1'h1;
      repeat (3) @(posedge clk);
      srst <= 1'h0;
      #1;
      `CHK("count after reset", 8'h00, cnt)
      wr_reg(ret_pkg::ADDR_HIGH_HALF, 4'h1);
      `CHK("reload low cleared", 8'h10, cnt)
      expect_reg("prescale after reset", ret_pkg::ADDR_PRESCALE, {1'h0, ret_pkg::PRESCALE_RESET});
      expect_reg("request after reset", ret_pkg::ADDR_IRQ_REQUEST, 4'h0);
      $display("test mid reset done");

      // Step period of every prescale code on the oscillator/4 source
      wr_reg(ret_pkg::ADDR_SOURCE_EDGE, 4'h0);
      for (int c = 0; c < 8; c++) begin
         wr_reg(ret_pkg::ADDR_PRESCALE, 4'(c));
         wait_step(n);
         wait_step(n);
         `CHK("step period", 4 * ratio[c], n)
      end
      $display("test prescale done");
      print_verdict();
   end
endmodule : tb_ret_timer
`default_nettype wire
